// ---- common/tscb_pkg.sv ----
// Function
// R01 - host_mode_override clear: device picks power mode; set: follow power_state_request
// R02 - config_done clear holds device in setup window, no sensing
// R03 - watchdog_en set enables watchdog; clearing acts only after next reset
// R04 - switch_change_evt_en gates events on switch_pin toggles
// R05 - aux and grid retune happen only while their enables are set
// R06 - switch_input_en activates switch input; switch_polarity 0 low, 1 high active
// R07 - near_evt_en gates events on channel proximity changes
// R08 - contact_evt_en gates touch events; click_evt_en gates snap events
// R09 - aux_near_evt_en gates events on alternate channel proximity changes
// R10 - retune_evt_en gates events on retune completion
// R11 - pad_evt_en gates finger events; motion_pattern_evt_en gates gesture events
// R12 - event_driven_comms clear: window every cycle; set: only on enabled event
// R13 - moving_avg_en, recursive_smooth_en, aux_count_smooth_en enable their filters
// R14 - recursive_damping_fixed clear: dynamic damping; set: fixed damping
// R15 - charging_style 0 projected, 1 self; receiver_bank_sel 0 group A, 1 B
// R16 - bidirectional_near set allows proximity trigger in both count directions
// R17 - aux_lowpower_channel_en makes low-power modes sense with alternate channel
// R18 - each aux mask bit includes its electrode when one
// R19 - remap bit 0 receiver, 1 transmitter; register only on small variants
// R20 - noise_detect_en, receiver_idle_float act; host writes two low bits zero
// R21 - sense_clock_sel doubles clock from 125 kHz at 000 to 16 MHz at 111; code truncates the divider, giving about 20.8 MHz at 111
// R22 - analog gap half cycle or about 10 ns; phase_stretch adds half cycle
// R23 - power_state_request acts only under host control; 000 active to 100 deepest
// R24 - unused bits read zero and ignore writes
package tscb_pkg;
   // ----------------------------------------
   // register indices
   // ----------------------------------------
   localparam logic [3:0] REG_SYS = 4'h0;
   localparam logic [3:0] REG_EVT = 4'h1;
   localparam logic [3:0] REG_FLT = 4'h2;
   localparam logic [3:0] REG_AUX = 4'h3;
   localparam logic [3:0] REG_REMAP = 4'h4;
   localparam logic [3:0] REG_HWA = 4'h5;
   localparam logic [3:0] REG_HWB = 4'h6;
   localparam logic [3:0] REG_PSR = 4'h7;
   localparam logic [3:0] REG_RXM_H = 4'h8;
   localparam logic [3:0] REG_RXM_L = 4'h9;
   localparam logic [3:0] REG_TXM_H = 4'hA;
   localparam logic [3:0] REG_TXM_L = 4'hB;
   // ----------------------------------------
   // writable masks and reset values
   // ----------------------------------------
   localparam logic [7:0] MASK_SYS = 8'hFF;
   localparam logic [7:0] MASK_EVT = 8'hFF;
   localparam logic [7:0] MASK_FLT = 8'h0F;
   localparam logic [7:0] MASK_AUX = 8'hF0;
   localparam logic [7:0] MASK_HWA = 8'h24;
   localparam logic [7:0] MASK_HWB = 8'h73;
   localparam logic [7:0] MASK_PSR = 8'h07;
   localparam logic [7:0] RST_CFG = 8'h00;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int B_MANUAL = 7;
   localparam int B_DONE = 6;
   localparam int B_WDT = 5;
   localparam int B_SWEVT = 4;
   localparam int B_AUXRT = 3;
   localparam int B_GRIDRT = 2;
   localparam int B_SWPOL = 1;
   localparam int B_SWEN = 0;
   localparam int B_NEAR = 7;
   localparam int B_CONTACT = 6;
   localparam int B_CLICK = 5;
   localparam int B_AUXNEAR = 4;
   localparam int B_RTEVT = 3;
   localparam int B_PAD = 2;
   localparam int B_GEST = 1;
   localparam int B_EVMODE = 0;
   localparam int B_ND = 5;
   localparam int B_FLOAT = 2;
   localparam int B_GAP = 1;
   localparam int B_STRETCH = 0;
   localparam int CKSEL_LSB = 4;
   // ----------------------------------------
   // power modes and timing
   // ----------------------------------------
   localparam logic [2:0] MODE_ACTIVE = 3'h0;
   localparam logic [2:0] MODE_DEEPEST = 3'h4;
   localparam int CLK_MHZ = 125;
   localparam int SENSE_BASE_KHZ = 125;
   localparam int SENSE_BASE_DIV = CLK_MHZ * 1000 / (SENSE_BASE_KHZ * 2);
endpackage

// ---- core/tscb_sync.sv ----
`timescale 1ns/1ns
module tscb_sync (
   // clock
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // pin
   input wire logic pin_in,
   output logic level_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_out <= 1'b0;
      end else if (ce_in) begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_out <= s3_r;
         end
      end
   end
endmodule

// ---- core/tscb_bank.sv ----
`timescale 1ns/1ns
module tscb_bank #(
   parameter bit SMALL_VARIANT = 1'b1,
   parameter int AUX_MASK_W = 16
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // register port
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out,
   // pins
   input wire logic switch_pin_in,
   // sensing core events
   input wire logic cycle_end_in,
   input wire logic near_chg_in,
   input wire logic contact_chg_in,
   input wire logic click_chg_in,
   input wire logic aux_near_chg_in,
   input wire logic retune_done_in,
   input wire logic pad_act_in,
   input wire logic gesture_in,
   input wire logic [2:0] auto_mode_in,
   input wire logic count_up_in,
   input wire logic count_down_in,
   // controls to sensing core
   output logic [2:0] power_mode_out,
   output logic sensing_en_out,
   output logic watchdog_en_out,
   output logic switch_active_out,
   output logic aux_retune_en_out,
   output logic grid_retune_en_out,
   output logic comm_window_out,
   output logic event_out,
   output logic moving_avg_out,
   output logic recursive_out,
   output logic damping_fixed_out,
   output logic aux_smooth_out,
   output logic self_charge_out,
   output logic bank_b_out,
   output logic near_trig_out,
   output logic use_aux_channel_out,
   output logic [AUX_MASK_W-1:0] aux_receiver_member_out,
   output logic [AUX_MASK_W-1:0] aux_transmit_member_out,
   output logic [7:0] electrode_tx_out,
   output logic noise_detect_out,
   output logic rx_float_out,
   output logic sense_clk_out,
   output logic gap_short_out,
   output logic [1:0] up_extra_half_out,
   output logic [1:0] pass_extra_half_out
);
   // mask widths the ports cannot carry are refused at elaboration
   if (AUX_MASK_W < 1 || AUX_MASK_W > 16) begin
      $error("AUX_MASK_W must be 1..16");
   end

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] sys_r;
   logic [7:0] evt_r;
   logic [7:0] flt_r;
   logic [7:0] aux_r;
   logic [7:0] remap_r;
   logic [7:0] hwa_r;
   logic [7:0] hwb_r;
   logic [7:0] psr_r;
   logic [15:0] rxm_r;
   logic [15:0] txm_r;
   logic wdt_r;
   logic sw_lvl;
   logic sw_prev_r;
   logic [2:0] auto_mode_r;

   function automatic logic [7:0] wmask(input logic [7:0] m, input logic [7:0] d);
      return d & m;
   endfunction

   function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] idx, input logic we);
      return we && (a == idx);
   endfunction

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sys_r <= tscb_pkg::RST_CFG;
         evt_r <= tscb_pkg::RST_CFG;
         flt_r <= tscb_pkg::RST_CFG;
         aux_r <= tscb_pkg::RST_CFG;
         remap_r <= tscb_pkg::RST_CFG;
         hwa_r <= tscb_pkg::RST_CFG;
         hwb_r <= tscb_pkg::RST_CFG;
         psr_r <= tscb_pkg::RST_CFG;
      end else if (ce_in) begin
         // unused positions never store a one
         if (wr_hit(addr_in, tscb_pkg::REG_SYS, wr_en_in)) begin
            sys_r <= wmask(tscb_pkg::MASK_SYS, wdata_in); // R24
         end
         if (wr_hit(addr_in, tscb_pkg::REG_EVT, wr_en_in)) begin
            evt_r <= wmask(tscb_pkg::MASK_EVT, wdata_in);
         end
         if (wr_hit(addr_in, tscb_pkg::REG_FLT, wr_en_in)) begin
            flt_r <= wmask(tscb_pkg::MASK_FLT, wdata_in); // R24
         end
         if (wr_hit(addr_in, tscb_pkg::REG_AUX, wr_en_in)) begin
            aux_r <= wmask(tscb_pkg::MASK_AUX, wdata_in); // R24
         end
         if (SMALL_VARIANT && wr_hit(addr_in, tscb_pkg::REG_REMAP, wr_en_in)) begin
            remap_r <= wdata_in; // R19
         end
         if (wr_hit(addr_in, tscb_pkg::REG_HWA, wr_en_in)) begin
            hwa_r <= wmask(tscb_pkg::MASK_HWA, wdata_in); // R20
         end
         if (wr_hit(addr_in, tscb_pkg::REG_HWB, wr_en_in)) begin
            hwb_r <= wmask(tscb_pkg::MASK_HWB, wdata_in); // R24
         end
         if (wr_hit(addr_in, tscb_pkg::REG_PSR, wr_en_in)) begin
            psr_r <= wmask(tscb_pkg::MASK_PSR, wdata_in);
         end
      end
   end

   // mask registers, sent high byte then low byte
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rxm_r <= 16'h0000;
         txm_r <= 16'h0000;
      end else if (ce_in) begin
         if (wr_hit(addr_in, tscb_pkg::REG_RXM_H, wr_en_in)) begin
            rxm_r[15:8] <= wdata_in;
         end
         if (wr_hit(addr_in, tscb_pkg::REG_RXM_L, wr_en_in)) begin
            rxm_r[7:0] <= wdata_in;
         end
         if (wr_hit(addr_in, tscb_pkg::REG_TXM_H, wr_en_in)) begin
            txm_r[15:8] <= wdata_in;
         end
         if (wr_hit(addr_in, tscb_pkg::REG_TXM_L, wr_en_in)) begin
            txm_r[7:0] <= wdata_in;
         end
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   logic [15:0] rxm_v;
   logic [15:0] txm_v;
   assign rxm_v = rxm_r & 16'((32'h1 << AUX_MASK_W) - 1);
   assign txm_v = txm_r & 16'((32'h1 << AUX_MASK_W) - 1);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
         rvalid_out <= 1'b0;
      end else if (ce_in) begin
         rvalid_out <= rd_en_in;
         if (rd_en_in) begin
            case (addr_in)
               tscb_pkg::REG_SYS: rdata_out <= sys_r;
               tscb_pkg::REG_EVT: rdata_out <= evt_r;
               tscb_pkg::REG_FLT: rdata_out <= flt_r;
               tscb_pkg::REG_AUX: rdata_out <= aux_r;
               tscb_pkg::REG_REMAP: rdata_out <= SMALL_VARIANT ? remap_r : 8'h00; // R19
               tscb_pkg::REG_HWA: rdata_out <= hwa_r;
               tscb_pkg::REG_HWB: rdata_out <= hwb_r;
               tscb_pkg::REG_PSR: rdata_out <= psr_r;
               tscb_pkg::REG_RXM_H: rdata_out <= rxm_v[15:8];
               tscb_pkg::REG_RXM_L: rdata_out <= rxm_v[7:0];
               tscb_pkg::REG_TXM_H: rdata_out <= txm_v[15:8];
               tscb_pkg::REG_TXM_L: rdata_out <= txm_v[7:0];
               default: rdata_out <= 8'h00; // R24
            endcase
         end
      end
   end

   // ----------------------------------------
   // system control
   // ----------------------------------------
   // watchdog latches on, only a reset turns it off
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wdt_r <= 1'b0;
      end else if (ce_in && sys_r[tscb_pkg::B_WDT]) begin
         wdt_r <= 1'b1; // R03
      end
   end
   assign watchdog_en_out = wdt_r;

   assign sensing_en_out = sys_r[tscb_pkg::B_DONE]; // R02

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         auto_mode_r <= tscb_pkg::MODE_ACTIVE;
      end else if (ce_in) begin
         auto_mode_r <= (auto_mode_in > tscb_pkg::MODE_DEEPEST) ? tscb_pkg::MODE_DEEPEST : auto_mode_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         power_mode_out <= tscb_pkg::MODE_ACTIVE;
      end else if (ce_in) begin
         if (!sys_r[tscb_pkg::B_DONE]) begin
            power_mode_out <= tscb_pkg::MODE_ACTIVE; // R02
         end else if (sys_r[tscb_pkg::B_MANUAL]) begin
            power_mode_out <= (psr_r[2:0] > tscb_pkg::MODE_DEEPEST) ? power_mode_out : psr_r[2:0]; // R23
         end else begin
            power_mode_out <= auto_mode_r; // R01
         end
      end
   end

   // switch input
   tscb_sync u_sw_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .pin_in(switch_pin_in),
      .level_out(sw_lvl)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sw_prev_r <= 1'b0;
      end else if (ce_in) begin
         sw_prev_r <= sw_lvl;
      end
   end

   logic sw_en;
   logic sw_toggle;
   assign sw_en = sys_r[tscb_pkg::B_SWEN];
   assign switch_active_out = sw_en && (sw_lvl == sys_r[tscb_pkg::B_SWPOL]); // R06
   assign sw_toggle = sw_en && (sw_lvl != sw_prev_r) && sys_r[tscb_pkg::B_SWEVT]; // R04

   assign aux_retune_en_out = sys_r[tscb_pkg::B_DONE] && sys_r[tscb_pkg::B_AUXRT]; // R05
   assign grid_retune_en_out = sys_r[tscb_pkg::B_DONE] && sys_r[tscb_pkg::B_GRIDRT]; // R05

   // ----------------------------------------
   // events and comm window
   // ----------------------------------------
   logic evt_now;
   logic evt_pend_r;
   assign evt_now = sw_toggle // R04
      || (near_chg_in && evt_r[tscb_pkg::B_NEAR]) // R07
      || (contact_chg_in && evt_r[tscb_pkg::B_CONTACT]) // R08
      || (click_chg_in && evt_r[tscb_pkg::B_CLICK]) // R08
      || (aux_near_chg_in && evt_r[tscb_pkg::B_AUXNEAR]) // R09
      || (retune_done_in && evt_r[tscb_pkg::B_RTEVT]) // R10
      || (pad_act_in && evt_r[tscb_pkg::B_PAD]) // R11
      || (gesture_in && evt_r[tscb_pkg::B_GEST]); // R11

   // an event in the cycle-end cycle joins this window
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         evt_pend_r <= 1'b0;
         event_out <= 1'b0;
         comm_window_out <= 1'b0;
      end else if (ce_in) begin
         event_out <= evt_now;
         comm_window_out <= 1'b0;
         if (cycle_end_in && sys_r[tscb_pkg::B_DONE]) begin
            evt_pend_r <= 1'b0;
            comm_window_out <= !evt_r[tscb_pkg::B_EVMODE] || evt_pend_r || evt_now; // R12
         end else if (evt_now) begin
            evt_pend_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // filters and channel setup
   // ----------------------------------------
   assign moving_avg_out = flt_r[1]; // R13
   assign recursive_out = flt_r[0]; // R13
   assign aux_smooth_out = flt_r[3]; // R13
   assign damping_fixed_out = flt_r[2]; // R14
   assign self_charge_out = aux_r[7]; // R15
   assign bank_b_out = aux_r[6]; // R15
   // self sensing moves counts down, projected moves them up
   assign near_trig_out = aux_r[5] ? (count_up_in || count_down_in)
                                  : (aux_r[7] ? count_down_in : count_up_in); // R16
   assign use_aux_channel_out = aux_r[4] && (power_mode_out >= 3'h3); // R17
   assign aux_receiver_member_out = rxm_r[AUX_MASK_W-1:0]; // R18
   assign aux_transmit_member_out = txm_r[AUX_MASK_W-1:0]; // R18
   assign electrode_tx_out = SMALL_VARIANT ? remap_r : 8'h00; // R19
   assign noise_detect_out = hwa_r[tscb_pkg::B_ND]; // R20
   assign rx_float_out = hwa_r[tscb_pkg::B_FLOAT]; // R20

   // ----------------------------------------
   // sensing clock and phase timing
   // ----------------------------------------
   logic [2:0] cksel;
   logic [9:0] half_div;
   logic [9:0] div_cnt_r;
   assign cksel = hwb_r[tscb_pkg::CKSEL_LSB +: 3];
   // half period in core cycles, floored at one
   assign half_div = (10'(tscb_pkg::SENSE_BASE_DIV) >> cksel) == 10'h000 ? 10'h001
                     : (10'(tscb_pkg::SENSE_BASE_DIV) >> cksel); // R21

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_cnt_r <= 10'h000;
         sense_clk_out <= 1'b0;
      end else if (ce_in) begin
         if (!sys_r[tscb_pkg::B_DONE]) begin
            div_cnt_r <= 10'h000;
            sense_clk_out <= 1'b0; // R02
         end else if (div_cnt_r + 10'h001 >= half_div) begin
            div_cnt_r <= 10'h000;
            sense_clk_out <= !sense_clk_out; // R21
         end else begin
            div_cnt_r <= div_cnt_r + 10'h001;
         end
      end
   end

   // timing in half sensing cycles added to each phase
   assign gap_short_out = hwb_r[tscb_pkg::B_GAP]; // R22
   assign up_extra_half_out = 2'({1'b0, hwb_r[tscb_pkg::B_GAP]} * 2'h2) + 2'({1'b0, hwb_r[tscb_pkg::B_STRETCH]}); // R22
   assign pass_extra_half_out = {1'b0, hwb_r[tscb_pkg::B_STRETCH]}; // R22

   // ----------------------------------------
   // checks
   // ----------------------------------------
   wdt_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in) // R03
      $past(wdt_r) && !$past(rst_in) |-> wdt_r) else $error("watchdog cleared without reset");
   setup_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // R02
      ce_in && !sys_r[tscb_pkg::B_DONE]
      |=> !comm_window_out && !sense_clk_out && (power_mode_out == tscb_pkg::MODE_ACTIVE))
      else $error("sensing in setup");
   unused_zero_a: assert property (@(posedge clk_in) disable iff (rst_in) // R24
      (flt_r[7:4] == 4'h0) && (aux_r[3:0] == 4'h0) && (hwa_r[1:0] == 2'b00)) else $error("unused bit set");
   host_mode_a: assert property (@(posedge clk_in) disable iff (rst_in) // R01
      ce_in && sys_r[6] && sys_r[7] && psr_r[2:0] <= 3'h4 && $stable(psr_r) && $stable(sys_r)
      |=> power_mode_out == $past(psr_r[2:0])) else $error("host mode not followed");
   stream_win_a: assert property (@(posedge clk_in) disable iff (rst_in) // R12
      ce_in && cycle_end_in && sys_r[6] && !evt_r[0] |=> comm_window_out) else $error("missing window");
   event_win_a: assert property (@(posedge clk_in) disable iff (rst_in) // R12
      comm_window_out && $past(evt_r[0]) |-> $past(evt_pend_r || evt_now)) else $error("window without event");
   switch_mute_a: assert property (@(posedge clk_in) disable iff (rst_in) // R06
      !sys_r[tscb_pkg::B_SWEN] |-> !sw_toggle && !switch_active_out) else $error("switch active while off");
   near_dir_a: assert property (@(posedge clk_in) disable iff (rst_in) // R16
      !aux_r[5] && !aux_r[7] && count_down_in && !count_up_in |-> !near_trig_out) else $error("reverse trigger");
endmodule

// ---- tb/tscb_host.sv ----
`timescale 1ns/1ns
module tscb_host (
   // clock
   input wire logic clk_in,
   // register port
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [3:0] addr_out,
   output logic [7:0] wdata_out,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in
);
   // ----------------------------------------
   // host register accesses
   // ----------------------------------------
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 4'h0;
      wdata_out = 8'h00;
   end
   task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_en_out <= 1'b1;
      addr_out <= a;
      // internal-use bits always go out as zero
      wdata_out <= (a == tscb_pkg::REG_HWA) ? (d & 8'hFC) : d;
      @(posedge clk_in);
      wr_en_out <= 1'b0;
   endtask
   task automatic read_reg(input logic [3:0] a, output logic [7:0] d, output bit ok);
      @(posedge clk_in);
      rd_en_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_in);
      rd_en_out <= 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (int t = 0; t < 8 && !ok; t++) begin
         @(posedge clk_in);
         if (rvalid_in === 1'b1) begin
            ok = 1'b1;
            d = rdata_in;
         end
      end
   endtask
endmodule

// ---- tb/touch_sensor_config_bank_tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module touch_sensor_config_bank_tb;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic switch_pin_in = 1'b0;
   logic [7:0] pv = 8'h00;
   logic [2:0] auto_mode_in = 3'h0;
   logic count_up_in = 1'b0;
   logic count_down_in = 1'b0;
   logic wr_en_in, rd_en_in, rvalid_out, sensing_en_out, watchdog_en_out, switch_active_out;
   logic [3:0] addr_in;
   logic [7:0] wdata_in, rdata_out, electrode_tx_out, d;
   logic [2:0] power_mode_out;
   logic [15:0] aux_receiver_member_out, aux_transmit_member_out;
   logic [1:0] up_extra_half_out, pass_extra_half_out;
   logic aux_retune_en_out, grid_retune_en_out, comm_window_out, event_out, moving_avg_out, recursive_out;
   logic damping_fixed_out, aux_smooth_out, self_charge_out, bank_b_out, near_trig_out, use_aux_channel_out;
   logic noise_detect_out, rx_float_out, sense_clk_out, gap_short_out;
   logic [7:0] shd [16];
   logic [19:0] pt [7] = '{20'hC0303, 20'hC0202, 20'hC0512, 20'h40511, 20'h40044, 20'h00040, 20'h40074};
   logic [31:0] seed = 32'hCE5813EB;
   int err_count = 0;
   int total_checks = 0;
   int n;
   initial forever #4 clk_in = ~clk_in;
   tscb_host u_tscb_host (.clk_in, .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .addr_out(addr_in),
      .wdata_out(wdata_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out));
   tscb_bank u_tscb_bank (.clk_in, .rst_in, .ce_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in, .rdata_out,
      .rvalid_out, .switch_pin_in, .cycle_end_in(pv[7]), .near_chg_in(pv[6]), .contact_chg_in(pv[5]),
      .click_chg_in(pv[4]), .aux_near_chg_in(pv[3]), .retune_done_in(pv[2]), .pad_act_in(pv[1]),
      .gesture_in(pv[0]), .auto_mode_in, .count_up_in, .count_down_in, .power_mode_out, .sensing_en_out,
      .watchdog_en_out, .switch_active_out, .aux_retune_en_out, .grid_retune_en_out, .comm_window_out,
      .event_out, .moving_avg_out, .recursive_out, .damping_fixed_out, .aux_smooth_out, .self_charge_out,
      .bank_b_out, .near_trig_out, .use_aux_channel_out, .aux_receiver_member_out, .aux_transmit_member_out,
      .electrode_tx_out, .noise_detect_out, .rx_float_out, .sense_clk_out, .gap_short_out,
      .up_extra_half_out, .pass_extra_half_out);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   function automatic logic [7:0] wmask(input int i);
      case (i)
         2: return tscb_pkg::MASK_FLT;
         3: return tscb_pkg::MASK_AUX;
         5: return tscb_pkg::MASK_HWA;
         6: return tscb_pkg::MASK_HWB;
         7: return tscb_pkg::MASK_PSR;
         default: return (i < 12) ? 8'hFF : 8'h00;
      endcase
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      u_tscb_host.write_reg(a, v);
      shd[a] = v & wmask(a);
   endtask
   task automatic rd(input logic [3:0] a);
      bit ok;
      u_tscb_host.read_reg(a, d, ok);
      if (!ok) begin
         err_count++;
         print_verdict();
      end
   endtask
   task automatic pulse(input int i);
      @(posedge clk_in);
      pv[i] <= 1'b1;
      @(posedge clk_in);
      pv[i] <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic do_reset();
      @(posedge clk_in);
      rst_in <= 1'b1;
      tick(12);
      rst_in <= 1'b0;
   endtask
   task automatic half_period(output int cnt);
      logic s;
      @(posedge clk_in);
      s = sense_clk_out;
      for (int t = 0; t < 1200 && sense_clk_out === s; t++) @(posedge clk_in);
      s = sense_clk_out;
      cnt = 0;
      for (int t = 0; t < 1200 && sense_clk_out === s; t++) begin
         @(posedge clk_in);
         cnt++;
      end
   endtask
   initial begin
      #400000;
      err_count++;
      print_verdict();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      do_reset();
      for (int i = 0; i < 16; i++) begin
         rd(4'(i));
         `CHK("reset rdata", 8'h00, d)
      end
      done("reset");
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            wr(4'(i), seed[7:0]);
            rd(4'(i));
            `CHK("rdata", shd[i], d)
         end
         tick(1);
         `CHK("sensing_en", shd[0][6], sensing_en_out)
         `CHK("aux_retune", shd[0][6] & shd[0][3], aux_retune_en_out)
         `CHK("grid_retune", shd[0][6] & shd[0][2], grid_retune_en_out)
         `CHK("filters", shd[2][3:0], {aux_smooth_out, damping_fixed_out, moving_avg_out, recursive_out})
         `CHK("aux setup", shd[3][7:6], {self_charge_out, bank_b_out})
         `CHK("rx member", {shd[8], shd[9]}, aux_receiver_member_out)
         `CHK("tx member", {shd[10], shd[11]}, aux_transmit_member_out)
         `CHK("electrode_tx", shd[4], electrode_tx_out)
         `CHK("hw a", {shd[5][5], shd[5][2]}, {noise_detect_out, rx_float_out})
         `CHK("gap", shd[6][1], gap_short_out)
         `CHK("up extra", {shd[6][1], 1'b0} + {1'b0, shd[6][0]}, up_extra_half_out)
         `CHK("pass extra", {1'b0, shd[6][0]}, pass_extra_half_out)
      end
      @(posedge clk_in);
      ce_in <= 1'b0;
      u_tscb_host.write_reg(tscb_pkg::REG_FLT, ~shd[2]);
      @(posedge clk_in);
      ce_in <= 1'b1;
      `CHK("frozen filters", shd[2][3:0], {aux_smooth_out, damping_fixed_out, moving_avg_out, recursive_out})
      done("registers");
      wr(tscb_pkg::REG_SYS, 8'h20);
      wr(tscb_pkg::REG_SYS, 8'h00);
      tick(1);
      `CHK("watchdog set", 1'b1, watchdog_en_out)
      do_reset();
      tick(1);
      `CHK("watchdog reset", 1'b0, watchdog_en_out)
      done("watchdog");
      wr(tscb_pkg::REG_AUX, 8'h10);
      for (int k = 0; k < 7; k++) begin
         wr(tscb_pkg::REG_SYS, pt[k][19:12]);
         wr(tscb_pkg::REG_PSR, {4'h0, pt[k][11:8]});
         @(posedge clk_in);
         auto_mode_in <= pt[k][6:4];
         tick(5);
         `CHK("power_mode", pt[k][2:0], power_mode_out)
         `CHK("use_aux", pt[k][2:0] >= 3'h3, use_aux_channel_out)
      end
      done("power");
      wr(tscb_pkg::REG_SYS, 8'h40);
      for (int i = 0; i < 7; i++) begin
         for (int e = 0; e < 2; e++) begin
            wr(tscb_pkg::REG_EVT, 8'(e << (i + 1)) | 8'h01);
            pulse(i);
            `CHK("event_out", e[0], event_out)
            pulse(7);
            `CHK("comm_window", e[0], comm_window_out)
         end
      end
      wr(tscb_pkg::REG_EVT, 8'h00);
      pulse(7);
      `CHK("comm_window", 1'b1, comm_window_out)
      done("events");
      for (int e = 0; e < 2; e++) begin
         wr(tscb_pkg::REG_SYS, 8'h41 | 8'(e << 4));
         wr(tscb_pkg::REG_EVT, 8'h01);
         @(posedge clk_in);
         switch_pin_in <= ~switch_pin_in;
         n = 0;
         repeat (12) begin
            @(posedge clk_in);
            n += (event_out === 1'b1);
         end
         `CHK("switch events", e, n)
      end
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_in);
         switch_pin_in <= k[2];
         wr(tscb_pkg::REG_SYS, 8'h40 | 8'(k[1:0]));
         tick(4);
         `CHK("switch_active", k[0] & (k[1] == k[2]), switch_active_out)
      end
      done("switch");
      for (int k = 0; k < 16; k++) begin
         wr(tscb_pkg::REG_AUX, {k[3], 1'b0, k[2], 5'h00});
         @(posedge clk_in);
         count_up_in <= k[1];
         count_down_in <= k[0];
         tick(2);
         `CHK("near_trig", k[2] ? (k[1] | k[0]) : (k[3] ? k[0] : k[1]), near_trig_out)
      end
      done("proximity");
      for (int s = 0; s < 8; s++) begin
         wr(tscb_pkg::REG_HWB, 8'(s << 4));
         half_period(n);
         `CHK("sense half period", 500 >> s, n)
      end
      done("sense clock");
      print_verdict();
   end
endmodule
